// *** opmode_defs.svh ***
`ifndef OPMODE_DEFS_SVH
`define OPMODE_DEFS_SVH

// register indices (printed offsets are not all multiples of four)
`define IDX_MODE_CONTROL 8'h0A
`define IDX_SLEEP_PERIOD_HIGH 8'h0B
`define IDX_SLEEP_PERIOD_LOW 8'h0C
`define IDX_LIMIT_HIGH 8'h0D
`define IDX_LIMIT_LOW 8'h0E
`define IDX_STATUS 8'h0F

// reset values
`define RST_MODE_CONTROL 8'h00
`define RST_SLEEP_PERIOD_HIGH 8'h80
`define RST_SLEEP_PERIOD_LOW 8'h00
`define RST_LIMIT_HIGH 8'h00
`define RST_LIMIT_LOW 8'h00

// field positions in mode_control
`define MC_MODE_HI 7
`define MC_MODE_LO 6
`define MC_SKIP_HI 5
`define MC_SKIP_LO 3
`define MC_CHOP_EN 2
`define MC_WAKE_EN 1
`define MC_RELEASE 0
// field positions in sleep_period_high
`define SP_UNIT 7

// skip count base: code 000 means three data cycles
`define SKIP_BASE 4'h3

// wake indicator pulse width
`define WAKE_PULSE_NS 1000
`define CLK_PERIOD_NS 25
`define WAKE_PULSE_CYC ((`WAKE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// axi response codes
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** opmode_pkg.sv ***
package opmode_pkg;

  typedef enum logic [1:0] {
    MODE_NORMAL_1 = 2'b00,
    MODE_NORMAL_2 = 2'b01,
    MODE_STANDBY_1 = 2'b10,
    MODE_STANDBY_2 = 2'b11
  } op_mode_type;

  typedef enum logic [2:0] {
    ST_STOP = 3'b000,
    ST_NORMAL_1 = 3'b001,
    ST_NORMAL_2 = 3'b010,
    ST_STANDBY_1 = 3'b011,
    ST_STANDBY_2 = 3'b100
  } op_state_type;

  // settings handed to the measurement logic
  typedef struct packed {
    op_mode_type mode;
    logic [3:0] skip_cycles;
    logic chop_en;
    logic wake_en;
    logic release_stop;
    logic unit_seconds;
    logic [14:0] sleep_period;
    logic [15:0] current_limit;
  } mode_cfg_type;

endpackage

// *** opmode_fsm.sv ***
`timescale 1ns/1ps
`include "opmode_defs.svh"

// ----------------------------------------
// operating state sequencer
// ----------------------------------------
module opmode_fsm (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // settings
  input opmode_pkg::mode_cfg_type cfg,
  // state
  output opmode_pkg::op_state_type state,
  output logic wake_indicator_pin
);
  import opmode_pkg::*;

  op_state_type state_q;
  op_state_type state_d;
  op_state_type target;
  logic [7:0] pulse_q;
  logic [7:0] pulse_d;
  logic leaving_standby;
  logic in_standby;

  // target follows the mode field
  always_comb begin
    unique case (cfg.mode)
      MODE_NORMAL_1: target = ST_NORMAL_1;
      MODE_NORMAL_2: target = ST_NORMAL_2;
      MODE_STANDBY_1: target = ST_STANDBY_1;
      MODE_STANDBY_2: target = ST_STANDBY_2;
    endcase
  end

  // stop holds until release is set; mode changes follow at once
  assign state_d = cfg.release_stop ? target : ST_STOP;

  assign in_standby = (state_q == ST_STANDBY_1) ||
                      (state_q == ST_STANDBY_2);
  assign leaving_standby = in_standby &&
    ((state_d == ST_NORMAL_1) || (state_d == ST_NORMAL_2));

  // a fixed-width pulse marks standby to normal; counter saturates at 0
  assign pulse_d = (leaving_standby && cfg.wake_en) ?
                   8'(`WAKE_PULSE_CYC) :
                   ((pulse_q != 8'h00) ? pulse_q - 8'h01 : 8'h00);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_STOP;
      pulse_q <= 8'h00;
    end else if (clk_en) begin
      state_q <= state_d;
      pulse_q <= pulse_d;
    end
  end

  assign state = state_q;
  // disabling the pin cuts an ongoing pulse too
  assign wake_indicator_pin = cfg.wake_en && (pulse_q != 8'h00);
endmodule // opmode_fsm

// *** operating_mode_control_regs.sv ***
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
`include "opmode_defs.svh"

// How it works
// - mode field 00/01 selects normal modes 1/2, 10/11 standby 1/2; resets 00
// - standby discards 3 to 10 data cycles by code before comparing threshold
// - chopper clock reaches its output pin only while its enable bit is set
// - wake indicator pin pulses on standby-to-normal only while enabled
// - stop state holds until release bit set, then enter the selected mode
// - sleep period unit bit: 0 milliseconds, 1 seconds; resets to seconds
// - sleep period: seven upper bits from high register, eight from low
// - second standby compares current against 16-bit limit, both bytes reset 0
module operating_mode_control_regs (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // measurement side
  input wire logic chopper_clock_in,
  input wire logic sample_valid,
  input wire logic [15:0] sample_current,
  output logic chopper_clock_output,
  output logic wake_indicator_pin,
  output logic limit_exceeded,
  output opmode_pkg::mode_cfg_type cfg,
  output opmode_pkg::op_state_type op_state
);
  import opmode_pkg::*;

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  logic [7:0] mode_control_q;
  logic [7:0] sleep_period_high_q;
  logic [7:0] sleep_period_low_q;
  logic [7:0] limit_high_q;
  logic [7:0] limit_low_q;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  // byte address is four times the register index
  function automatic logic [5:0] word_index(input logic [7:0] addr);
    return addr[7:2];
  endfunction

  function automatic logic idx_is(input logic [7:0] addr,
                                  input logic [7:0] idx);
    return (addr[1:0] == 2'b00) && ({2'b00, word_index(addr)} == idx);
  endfunction

  // ----------------------------------------
  // write channel
  // ----------------------------------------
  logic aw_held_q;
  logic w_held_q;
  logic [7:0] aw_addr_q;
  logic [7:0] w_byte_q;
  logic w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic do_write;
  logic aw_take;
  logic w_take;
  logic wr_hit_mc;
  logic wr_hit_sph;
  logic wr_hit_spl;
  logic wr_hit_lh;
  logic wr_hit_ll;
  logic wr_mapped;
  logic wr_en;

  // hold each half until both are in; no new write while response pends
  assign s_axi_awready = clk_en && !aw_held_q && !bvalid_q; // no lost take
  assign s_axi_wready = clk_en && !w_held_q && !bvalid_q; // while frozen
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign do_write = aw_held_q && w_held_q && !bvalid_q;

  assign wr_hit_mc = idx_is(aw_addr_q, `IDX_MODE_CONTROL);
  assign wr_hit_sph = idx_is(aw_addr_q, `IDX_SLEEP_PERIOD_HIGH);
  assign wr_hit_spl = idx_is(aw_addr_q, `IDX_SLEEP_PERIOD_LOW);
  assign wr_hit_lh = idx_is(aw_addr_q, `IDX_LIMIT_HIGH);
  assign wr_hit_ll = idx_is(aw_addr_q, `IDX_LIMIT_LOW);
  // status word reads fine but is not writable
  assign wr_mapped = wr_hit_mc || wr_hit_sph || wr_hit_spl ||
                     wr_hit_lh || wr_hit_ll;
  // only lane 0 carries register data
  assign wr_en = do_write && w_strb_q;

  // handshake state of the write path
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_byte_q <= 8'h00;
      w_strb_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
    end else if (clk_en) begin
      if (aw_take) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held_q <= 1'b1;
        w_byte_q <= s_axi_wdata[7:0];
        w_strb_q <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // ----------------------------------------
  // register update
  // ----------------------------------------
  // each byte is its own register; pairs are not latched together, so
  // software updates both halves before depending on the value
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_control_q <= `RST_MODE_CONTROL;
      sleep_period_high_q <= `RST_SLEEP_PERIOD_HIGH;
      sleep_period_low_q <= `RST_SLEEP_PERIOD_LOW;
      limit_high_q <= `RST_LIMIT_HIGH;
      limit_low_q <= `RST_LIMIT_LOW;
    end else if (clk_en && wr_en) begin
      if (wr_hit_mc) begin
        mode_control_q <= w_byte_q;
      end
      if (wr_hit_sph) begin
        sleep_period_high_q <= w_byte_q;
      end
      if (wr_hit_spl) begin
        sleep_period_low_q <= w_byte_q;
      end
      if (wr_hit_lh) begin
        limit_high_q <= w_byte_q;
      end
      if (wr_hit_ll) begin
        limit_low_q <= w_byte_q;
      end
    end
  end

  // ----------------------------------------
  // field decode
  // ----------------------------------------
  assign cfg.mode = op_mode_type'(
    mode_control_q[`MC_MODE_HI:`MC_MODE_LO]);
  // code 000..111 maps linearly onto 3..10 cycles
  assign cfg.skip_cycles = `SKIP_BASE +
    {1'b0, mode_control_q[`MC_SKIP_HI:`MC_SKIP_LO]};
  assign cfg.chop_en = mode_control_q[`MC_CHOP_EN];
  assign cfg.wake_en = mode_control_q[`MC_WAKE_EN];
  assign cfg.release_stop = mode_control_q[`MC_RELEASE];
  assign cfg.unit_seconds = sleep_period_high_q[`SP_UNIT];
  assign cfg.sleep_period = {sleep_period_high_q[6:0],
                             sleep_period_low_q};
  assign cfg.current_limit = {limit_high_q, limit_low_q};

  // gated pin; a plain and keeps the clock path free of flops
  assign chopper_clock_output = chopper_clock_in && cfg.chop_en;

  // ----------------------------------------
  // state sequencer
  // ----------------------------------------
  opmode_fsm opmode_fsm_i (
    .clk(clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .cfg(cfg),
    .state(op_state),
    .wake_indicator_pin(wake_indicator_pin)
  );

  // ----------------------------------------
  // standby threshold compare
  // ----------------------------------------
  logic [3:0] skipped_q;
  logic limit_q;
  logic in_standby;
  logic skip_done;
  op_state_type prev_state_q;

  assign in_standby = (op_state == ST_STANDBY_1) ||
                      (op_state == ST_STANDBY_2);
  assign skip_done = (skipped_q >= cfg.skip_cycles);

  // restart the discard count on every entry into a standby state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      skipped_q <= 4'h0;
      limit_q <= 1'b0;
      prev_state_q <= ST_STOP;
    end else if (clk_en) begin
      prev_state_q <= op_state;
      if (!in_standby || (op_state != prev_state_q)) begin
        skipped_q <= 4'h0;
        limit_q <= 1'b0;
      end else if (sample_valid && !skip_done) begin
        skipped_q <= skipped_q + 4'h1;
      end else if (sample_valid && op_state == ST_STANDBY_2) begin
        limit_q <= (sample_current > cfg.current_limit);
      end
    end
  end

  assign limit_exceeded = limit_q;

  // ----------------------------------------
  // read channel
  // ----------------------------------------
  logic rvalid_q;
  logic [7:0] rbyte_q;
  logic [1:0] rresp_q;
  logic [7:0] rd_mux;
  logic rd_mapped;
  logic ar_take;

  assign s_axi_arready = clk_en && !rvalid_q;
  assign ar_take = s_axi_arvalid && s_axi_arready;

  // read mux; status word shows the live state and compare result
  assign rd_mux =
    idx_is(s_axi_araddr, `IDX_MODE_CONTROL) ? mode_control_q :
    idx_is(s_axi_araddr, `IDX_SLEEP_PERIOD_HIGH) ? sleep_period_high_q :
    idx_is(s_axi_araddr, `IDX_SLEEP_PERIOD_LOW) ? sleep_period_low_q :
    idx_is(s_axi_araddr, `IDX_LIMIT_HIGH) ? limit_high_q :
    idx_is(s_axi_araddr, `IDX_LIMIT_LOW) ? limit_low_q :
    idx_is(s_axi_araddr, `IDX_STATUS) ?
      {3'b000, limit_q, wake_indicator_pin, op_state} : 8'h00;
  assign rd_mapped =
    idx_is(s_axi_araddr, `IDX_MODE_CONTROL) ||
    idx_is(s_axi_araddr, `IDX_SLEEP_PERIOD_HIGH) ||
    idx_is(s_axi_araddr, `IDX_SLEEP_PERIOD_LOW) ||
    idx_is(s_axi_araddr, `IDX_LIMIT_HIGH) ||
    idx_is(s_axi_araddr, `IDX_LIMIT_LOW) ||
    idx_is(s_axi_araddr, `IDX_STATUS);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rvalid_q <= 1'b0;
      rbyte_q <= 8'h00;
      rresp_q <= `RESP_OKAY;
    end else if (clk_en) begin
      if (ar_take) begin
        rvalid_q <= 1'b1;
        rbyte_q <= rd_mux;
        rresp_q <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = {24'h000000, rbyte_q};
  assign s_axi_rresp = rresp_q;
endmodule // operating_mode_control_regs

// *** operating_mode_control_regs_properties.sv ***
`timescale 1ns/1ps
// ----------------
// port checker
// ----------------
module opmode_checker
  import opmode_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // bus
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  // measurement side
  input wire logic chopper_clock_in,
  input wire logic chopper_clock_output,
  input wire logic wake_indicator_pin,
  input wire logic limit_exceeded,
  input opmode_pkg::mode_cfg_type cfg,
  input opmode_pkg::op_state_type op_state
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // state tracks the mode field one edge later
  property p_run;
    clk_en && cfg.release_stop |=> op_state == 3'($past(cfg.mode)) + 3'h1;
  endproperty
  a_run: assert property (p_run)
    else $error("state does not match mode field");
  property p_stop;
    clk_en && !cfg.release_stop |=> op_state == ST_STOP;
  endproperty
  a_stop: assert property (p_stop)
    else $error("left stop without release");
  property p_skip;
    cfg.skip_cycles inside {[3:10]};
  endproperty
  a_skip: assert property (p_skip)
    else $error("skip count out of range");
  property p_chop;
    chopper_clock_output == (chopper_clock_in & cfg.chop_en);
  endproperty
  a_chop: assert property (p_chop)
    else $error("chopper output gating wrong");
  property p_wake_off;
    !cfg.wake_en |-> !wake_indicator_pin;
  endproperty
  a_wake_off: assert property (p_wake_off)
    else $error("wake pin active while disabled");
  property p_wake_go;
    cfg.wake_en && op_state inside {ST_NORMAL_1, ST_NORMAL_2} &&
      $past(op_state) inside {ST_STANDBY_1, ST_STANDBY_2} |->
      wake_indicator_pin;
  endproperty
  a_wake_go: assert property (p_wake_go)
    else $error("no wake pulse on leaving standby");
  property p_wake_len;
    $rose(wake_indicator_pin) |-> (wake_indicator_pin || !cfg.wake_en) [*8];
  endproperty
  a_wake_len: assert property (p_wake_len)
    else $error("wake pulse too short");
  // write answer holds until taken; read answer follows one edge after the address
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold)
    else $error("write response dropped early");
  property p_rans;
    clk_en && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rans: assert property (p_rans)
    else $error("read answer late");
  // compare result only lives in the second standby mode
  property p_limit_mode;
    clk_en && op_state != ST_STANDBY_2 |=> !limit_exceeded;
  endproperty
  a_limit_mode: assert property (p_limit_mode)
    else $error("limit result outside second standby");
endmodule // opmode_checker

bind operating_mode_control_regs opmode_checker opmode_checker_i (
  .clk, .arst_n, .clk_en, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .chopper_clock_in,
  .chopper_clock_output, .wake_indicator_pin, .limit_exceeded, .cfg,
  .op_state
);

// *** operating_mode_control_regs_tb.sv ***
`timescale 1ns/1ps
`include "opmode_defs.svh"
// ----------------
// bench
// ----------------
module operating_mode_control_regs_tb;
  import opmode_pkg::*;
  localparam logic [7:0] MC = `IDX_MODE_CONTROL << 2;
  localparam logic [7:0] SH = `IDX_SLEEP_PERIOD_HIGH << 2;
  localparam logic [7:0] SL = `IDX_SLEEP_PERIOD_LOW << 2;
  localparam logic [7:0] LH = `IDX_LIMIT_HIGH << 2;
  localparam logic [7:0] LL = `IDX_LIMIT_LOW << 2;
  localparam logic [7:0] ST = `IDX_STATUS << 2;
  localparam int WAKE_CYC = `WAKE_PULSE_CYC;
  logic clk = 1'h0, arst_n = 1'h0, clk_en = 1'h1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic chopper_clock_in = 1'h0, sample_valid = 1'h0;
  logic [15:0] sample_current = 16'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, chopper_clock_output, wake_indicator_pin;
  logic limit_exceeded;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  mode_cfg_type cfg;
  op_state_type op_state;
  int error_cnt = 0, comparisons = 0, wake_cyc = 0;

  operating_mode_control_regs operating_mode_control_regs_i (
    .clk, .arst_n, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .chopper_clock_in, .sample_valid, .sample_current,
    .chopper_clock_output, .wake_indicator_pin, .limit_exceeded, .cfg,
    .op_state
  );

  always #12.5 clk = ~clk;
  // chopper source and wake pulse width counter
  always @(posedge clk) chopper_clock_in <= ~chopper_clock_in;
  always @(posedge clk) if (wake_indicator_pin) wake_cyc <= wake_cyc + 1;

  // ----------------
  // shared tasks
  // ----------------
  task automatic chk(input string s, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  // bus write; waits on the handshake, not on a fixed latency
  task automatic wr(input logic [7:0] a, d, input logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'h1;
    s_axi_wdata <= {24'h0, d};
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1 && n < 100);
    s_axi_bready <= 1'h0;
    chk("bresp", r, s_axi_bresp);
    if (n >= 100) error_cnt++;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1 && n < 100);
    s_axi_rready <= 1'h0;
    chk("rdata", e, s_axi_rdata);
    chk("rresp", r, s_axi_rresp);
    if (n >= 100) error_cnt++;
  endtask
  task automatic smp(input logic [15:0] v);
    @(posedge clk);
    sample_valid <= 1'h1;
    sample_current <= v;
    @(posedge clk);
    sample_valid <= 1'h0;
  endtask
  task automatic settle;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask

  // ----------------
  // scenarios
  // ----------------
  task automatic t_reset;
    @(negedge clk);
    chk("state", ST_STOP, op_state);
    rd(MC, 32'h00, 2'h0);
    rd(SH, 32'h80, 2'h0);
    rd(SL, 32'h00, 2'h0);
    rd(LH, 32'h00, 2'h0);
    rd(LL, 32'h00, 2'h0);
  endtask
  task automatic t_modes;
    for (int m = 0; m < 4; m++) begin
      wr(MC, {m[1:0], 6'h01}, 2'h0);
      settle();
      chk("mode", m, cfg.mode);
      chk("state", m + 1, op_state);
    end
    wr(MC, 8'hC0, 2'h0);
    settle();
    chk("state", ST_STOP, op_state);
  endtask
  task automatic t_skip;
    for (int c = 0; c < 8; c++) begin
      wr(MC, {2'h0, c[2:0], 3'h0}, 2'h0);
      rd(MC, {26'h0, c[2:0], 3'h0}, 2'h0);
      chk("skip", c + 3, cfg.skip_cycles);
    end
  endtask
  task automatic t_chop;
    wr(MC, 8'h00, 2'h0);
    repeat (2) begin
      @(negedge clk);
      chk("chop", 0, chopper_clock_output);
    end
    wr(MC, 8'h04, 2'h0);
    repeat (2) begin
      @(negedge clk);
      chk("chop", chopper_clock_in, chopper_clock_output);
    end
  endtask
  task automatic t_period;
    wr(SH, 8'h55, 2'h0);
    wr(SL, 8'hA3, 2'h0);
    @(negedge clk);
    chk("unit", 0, cfg.unit_seconds);
    chk("period", 15'h55A3, cfg.sleep_period);
    wr(SH, 8'hFF, 2'h0);
    @(negedge clk);
    chk("unit", 1, cfg.unit_seconds);
    chk("period", 15'h7FA3, cfg.sleep_period);
  endtask
  // standby 2 with code 000: three samples are skipped, compare is strict
  task automatic t_limit;
    wr(LH, 8'h12, 2'h0);
    wr(LL, 8'h34, 2'h0);
    rd(LL, 32'h34, 2'h0);
    chk("limit", 16'h1234, cfg.current_limit);
    wr(MC, 8'hC1, 2'h0);
    repeat (3) smp(16'hFFFF);
    settle();
    chk("limit hit", 0, limit_exceeded);
    smp(16'hFFFF);
    settle();
    chk("limit hit", 1, limit_exceeded);
    // enable low freezes the compare: a sample must not move it
    clk_en <= 1'h0;
    smp(16'h0000);
    settle();
    chk("limit frozen", 1, limit_exceeded);
    clk_en <= 1'h1;
    rd(ST, 32'h14, 2'h0);
    smp(16'h1234);
    settle();
    chk("limit hit", 0, limit_exceeded);
  endtask
  task automatic t_wake;
    for (int en = 1; en >= 0; en--) begin
      wr(MC, {6'h20, en[0], 1'h1}, 2'h0);
      settle();
      wake_cyc = 0;
      wr(MC, {6'h00, en[0], 1'h1}, 2'h0);
      repeat (60) @(posedge clk);
      @(negedge clk);
      chk("wake len", en * WAKE_CYC, wake_cyc);
    end
  endtask
  task automatic t_bad;
    rd(8'h40, 32'h0, 2'h2);
    rd(8'h29, 32'h0, 2'h2);
    wr(ST, 8'hFF, 2'h2);
    // lane 0 strobe low: answered okay, register left alone
    s_axi_wstrb <= 4'hE;
    wr(MC, 8'hFF, 2'h0);
    s_axi_wstrb <= 4'hF;
    rd(MC, 32'h01, 2'h0);
  endtask

  task automatic summarize;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clk);
    arst_n <= 1'h1;
    t_reset();
    t_modes();
    t_skip();
    t_chop();
    t_period();
    t_limit();
    t_wake();
    t_bad();
    summarize();
  end
  // watchdog: tests need about 350 cycles, allow 8000
  initial begin
    #200000;
    error_cnt++;
    summarize();
  end
endmodule // operating_mode_control_regs_tb
